// ### core/udb_pkg.sv
// Shared constants and types for the serial data buffer and its baud timing.
// Assumes a single system clock with a synchronous active-high reset.
package udb_pkg;

   // ************************************
   // Register map and reset values
   // ************************************
   localparam logic [7:0] UDB_SBUF_ADDR = 8'h99;
   localparam logic [7:0] UDB_SBUF_RESET = 8'h00;

   // ************************************
   // Timer clock prescale
   // ************************************
   localparam logic [1:0] UDB_PS_DIV12 = 2'h0;
   localparam logic [1:0] UDB_PS_DIV4 = 2'h1;
   localparam logic [1:0] UDB_PS_DIV48 = 2'h2;
   localparam logic [1:0] UDB_PS_EXT8 = 2'h3;
   localparam logic [5:0] UDB_DIV12 = 6'h0C;
   localparam logic [5:0] UDB_DIV4 = 6'h04;
   localparam logic [5:0] UDB_DIV48 = 6'h30;
   localparam logic [5:0] UDB_DIV_EXT = 6'h08;
   localparam logic [7:0] UDB_TIMER_TOP = 8'hFF;
   localparam logic [3:0] UDB_DATA_BITS = 4'h8;
   localparam int UDB_FIFO_DEPTH = 8;

   // ************************************
   // States
   // ************************************
   typedef enum logic [4:0] {
      UDB_TX_IDLE = 5'h01,
      UDB_TX_START = 5'h02,
      UDB_TX_DATA = 5'h04,
      UDB_TX_NINTH = 5'h08,
      UDB_TX_STOP = 5'h10
   } udb_tx_state_t;

   typedef enum logic [3:0] {
      UDB_RX_IDLE = 4'h1,
      UDB_RX_START = 4'h2,
      UDB_RX_DATA = 4'h4,
      UDB_RX_STOP = 4'h8
   } udb_rx_state_t;

   // ************************************
   // Carriers
   // ************************************
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } udb_sfr_t;

   typedef struct packed {
      logic nine_bit_mode;
      logic multiproc_check_enable;
      logic receive_enable_bit;
      logic ninth_tx_bit;
      logic timer_clock_select;
      logic [1:0] timer_prescale_code;
      logic [7:0] reload;
   } udb_cfg_t;

   typedef struct packed {
      logic [5:0] ps_cnt;
      logic ext_prev;
      logic [7:0] timer;
      logic ovf_phase;
      udb_tx_state_t tx_state;
      logic [8:0] tx_shift;
      logic [3:0] tx_cnt;
      logic txd;
      logic tx_done;
      udb_rx_state_t rx_state;
      logic rx_half;
      logic [8:0] rx_shift;
      logic [3:0] rx_cnt;
      logic rxd_prev;
      logic [7:0] rx_latch;
      logic ninth_rx;
      logic rx_done;
      logic [7:0] rdata;
   } udb_state_t;

endpackage

// ### core/udb_uart.sv
// Serial data buffer, transmit queue, baud timer, transmitter and receiver.
// Assumes the CPU register port and all pins are synchronous to clk.
//
// What this block does
// - One address, separate transmit and receive storage.
// - Written byte held until shifted out; a byte written while the queue is full is dropped.
// - Each byte the queue accepts starts its own transmission.
// - Read returns receive latch, transfer undisturbed.
// - Eight-bit buffer, cleared to zero at reset.
// - Direct clock, reload 0x96 gives 212 cycles.
// - Prescale codes select div12, div4, div48, ext/8.
// - External clock /8, reload 0x70 gives 2304.
// - Transmit flag set when the stop bit starts.
// - Stop bit loads latch if flag clear, check passes.
// - Nine-bit frame is start, eight, ninth, stop.
`timescale 1ns/1ps

// ************************************
// Transmit queue
// ************************************
module udb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rp];

   always_ff @(posedge clk) begin
      if (rst) begin
         wp <= '0;
         rp <= '0;
         count <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            mem[wp] <= in_data;
            wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
         end
         if (pop) begin
            rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
         end
         count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
         in_ready <= (count + (AW + 1)'(push) - (AW + 1)'(pop)) != (AW + 1)'(DEPTH);
         out_valid <= (count + (AW + 1)'(push) - (AW + 1)'(pop)) != '0;
      end
   end
endmodule

// ************************************
// Serial port core
// ************************************
module udb_uart
   import udb_pkg::*;
#(
   parameter int FIFO_DEPTH = UDB_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // CPU register port
   input wire udb_sfr_t sfr,
   output logic [7:0] sfr_rdata,
   output logic sfr_wr_ready,
   // Control bits and flag clears
   input wire udb_cfg_t cfg,
   input wire logic tx_done_clear,
   input wire logic rx_done_clear,
   // Status
   output logic tx_done_flag,
   output logic rx_done_flag,
   output logic ninth_rx_bit,
   // Line side
   input wire logic external_osc_clock,
   input wire logic rxd,
   output logic txd
);
   udb_state_t s;
   udb_state_t next_s;
   logic [5:0] ps_div;
   logic tm_tick;
   logic ovf;
   logic bit_tick;
   logic hit;
   logic q_valid;
   logic q_pop;
   logic [7:0] q_data;
   logic chk_bit;
   logic rx_sample;

   assign hit = sfr.addr == UDB_SBUF_ADDR;

   udb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
      .clk(clk),
      .rst(rst),
      .in_valid(sfr.wr && hit),
      .in_ready(sfr_wr_ready),
      .in_data(sfr.wdata),
      .out_valid(q_valid),
      .out_ready(q_pop),
      .out_data(q_data)
   );

   // ************************************
   // Baud timer
   // ************************************
   always_comb begin
      case (cfg.timer_prescale_code)
         UDB_PS_DIV12: ps_div = UDB_DIV12;
         UDB_PS_DIV4: ps_div = UDB_DIV4;
         UDB_PS_DIV48: ps_div = UDB_DIV48;
         default: ps_div = UDB_DIV_EXT;
      endcase
      if (cfg.timer_clock_select) begin
         tm_tick = 1'b1;
      end else if (cfg.timer_prescale_code == UDB_PS_EXT8) begin
         tm_tick = external_osc_clock && !s.ext_prev && s.ps_cnt == ps_div - 6'h01;
      end else begin
         tm_tick = s.ps_cnt == ps_div - 6'h01;
      end
   end

   assign ovf = tm_tick && s.timer == UDB_TIMER_TOP;
   assign bit_tick = ovf && s.ovf_phase;
   assign q_pop = s.tx_state == UDB_TX_IDLE && q_valid;
   assign rx_sample = ovf && s.rx_half;
   assign chk_bit = cfg.nine_bit_mode ? s.rx_shift[8] : rxd;

   // ************************************
   // Next state
   // ************************************
   always_comb begin
      next_s = s;
      next_s.ext_prev = external_osc_clock;
      next_s.rxd_prev = rxd;
      if (cfg.timer_clock_select) begin
         next_s.ps_cnt = '0;
      end else if (cfg.timer_prescale_code == UDB_PS_EXT8) begin
         if (external_osc_clock && !s.ext_prev) begin
            next_s.ps_cnt = tm_tick ? 6'h00 : s.ps_cnt + 6'h01;
         end
      end else begin
         next_s.ps_cnt = tm_tick ? 6'h00 : s.ps_cnt + 6'h01;
      end
      if (tm_tick) begin
         next_s.timer = ovf ? cfg.reload : s.timer + 8'h01;
      end
      if (ovf) begin
         next_s.ovf_phase = !s.ovf_phase;
      end

      // Set wins over a clear landing in the same cycle.
      if (tx_done_clear) begin
         next_s.tx_done = 1'b0;
      end
      if (rx_done_clear) begin
         next_s.rx_done = 1'b0;
      end

      // Transmitter.
      case (s.tx_state)
         UDB_TX_IDLE: begin
            if (q_valid) begin
               next_s.tx_shift = {cfg.ninth_tx_bit, q_data};
               next_s.tx_state = UDB_TX_START;
            end
         end
         UDB_TX_START: begin
            if (bit_tick) begin
               next_s.txd = 1'b0;
               next_s.tx_cnt = '0;
               next_s.tx_state = UDB_TX_DATA;
            end
         end
         UDB_TX_DATA: begin
            if (bit_tick) begin
               if (s.tx_cnt == UDB_DATA_BITS) begin
                  if (cfg.nine_bit_mode) begin
                     next_s.txd = s.tx_shift[8];
                     next_s.tx_state = UDB_TX_NINTH;
                  end else begin
                     next_s.txd = 1'b1;
                     next_s.tx_done = 1'b1;
                     next_s.tx_state = UDB_TX_STOP;
                  end
               end else begin
                  next_s.txd = s.tx_shift[0];
                  next_s.tx_shift = {s.tx_shift[8], 1'b0, s.tx_shift[7:1]};
                  next_s.tx_cnt = s.tx_cnt + 4'h1;
               end
            end
         end
         UDB_TX_NINTH: begin
            if (bit_tick) begin
               next_s.txd = 1'b1;
               next_s.tx_done = 1'b1;
               next_s.tx_state = UDB_TX_STOP;
            end
         end
         UDB_TX_STOP: begin
            if (bit_tick) begin
               next_s.tx_state = UDB_TX_IDLE;
            end
         end
         default: next_s.tx_state = UDB_TX_IDLE;
      endcase

      // Receiver. The start edge is resolved to half a bit, a limitation of
      // sharing one free-running timer with the transmitter.
      case (s.rx_state)
         UDB_RX_IDLE: begin
            if (cfg.receive_enable_bit && s.rxd_prev && !rxd) begin
               next_s.rx_half = 1'b0;
               next_s.rx_state = UDB_RX_START;
            end
         end
         UDB_RX_START: begin
            if (ovf) begin
               next_s.rx_cnt = '0;
               next_s.rx_state = rxd ? UDB_RX_IDLE : UDB_RX_DATA;
            end
         end
         UDB_RX_DATA: begin
            if (ovf) begin
               next_s.rx_half = !s.rx_half;
            end
            if (rx_sample) begin
               next_s.rx_shift = {rxd, s.rx_shift[8:1]};
               next_s.rx_cnt = s.rx_cnt + 4'h1;
               if (s.rx_cnt == (cfg.nine_bit_mode ? UDB_DATA_BITS : UDB_DATA_BITS - 4'h1)) begin
                  next_s.rx_state = UDB_RX_STOP;
               end
            end
         end
         UDB_RX_STOP: begin
            if (ovf) begin
               next_s.rx_half = !s.rx_half;
            end
            if (rx_sample) begin
               next_s.rx_state = UDB_RX_IDLE;
               if (!s.rx_done && (!cfg.multiproc_check_enable || chk_bit)) begin
                  next_s.rx_latch = cfg.nine_bit_mode ? s.rx_shift[7:0] : s.rx_shift[8:1];
                  next_s.ninth_rx = chk_bit;
                  next_s.rx_done = 1'b1;
               end
            end
         end
         default: next_s.rx_state = UDB_RX_IDLE;
      endcase

      next_s.rdata = (sfr.rd && hit) ? s.rx_latch : 8'h00;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.txd <= 1'b1;
         s.rxd_prev <= 1'b1;
         s.rx_latch <= UDB_SBUF_RESET;
         s.rdata <= UDB_SBUF_RESET;
         s.tx_state <= UDB_TX_IDLE;
         s.rx_state <= UDB_RX_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign sfr_rdata = s.rdata;
   assign tx_done_flag = s.tx_done;
   assign rx_done_flag = s.rx_done;
   assign ninth_rx_bit = s.ninth_rx;
   assign txd = s.txd;

   // ************************************
   // Assertions
   // ************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_read_latch;
      sfr.rd && hit |=> sfr_rdata == $past(s.rx_latch);
   endproperty
   a_read_latch: assert property (p_read_latch) else $error("read not from latch");

   property p_pop_holds;
      q_pop |=> s.tx_shift[7:0] == $past(q_data);
   endproperty
   a_pop_holds: assert property (p_pop_holds) else $error("byte not held");

   property p_start_tx;
      q_pop |=> s.tx_state == UDB_TX_START;
   endproperty
   a_start_tx: assert property (p_start_tx) else $error("write did not start");

   sequence s_start_bit;
      s.tx_state == UDB_TX_START && bit_tick;
   endsequence
   property p_start_low;
      s_start_bit |=> txd == 1'b0 && s.tx_state == UDB_TX_DATA;
   endproperty
   a_start_low: assert property (p_start_low) else $error("no start bit");

   property p_tx_flag;
      s.tx_state == UDB_TX_DATA && bit_tick && s.tx_cnt == UDB_DATA_BITS
         && !cfg.nine_bit_mode |=> tx_done_flag && txd;
   endproperty
   a_tx_flag: assert property (p_tx_flag) else $error("tx flag missing");

   property p_rx_guard;
      rx_done_flag && !rx_done_clear |=> $stable(s.rx_latch) && rx_done_flag;
   endproperty
   a_rx_guard: assert property (p_rx_guard) else $error("latch overwritten");

   property p_reload;
      ovf |=> s.timer == $past(cfg.reload);
   endproperty
   a_reload: assert property (p_reload) else $error("timer not reloaded");

   property p_div4;
      tm_tick && !cfg.timer_clock_select && cfg.timer_prescale_code == UDB_PS_DIV4
         |=> !tm_tick [*3];
   endproperty
   a_div4: assert property (p_div4) else $error("divide by four wrong");
endmodule

// ### test/udb_remote.sv
// Remote serial device: decodes frames seen on txd and sends frames on rxd.
// Assumes txd changes only just after rising clk edges.
`timescale 1ns/1ps
module udb_remote (
   // Clock
   input wire logic clk,
   // Line
   input wire logic txd,
   output logic rxd,
   // Setup and probe
   input wire logic mon_en,
   input wire logic nine,
   input wire logic flag_probe,
   input wire logic [15:0] bit_clks
);
   logic [11:0] got_q[$];
   logic [11:0] f;
   int start_len;

   // ************************************
   // Frame decoder
   // ************************************
   // The start length is only a true bit period when data bit 0 is high.
   // frame layout decode
   initial begin
      rxd = 1'b1;
      forever begin
         @(negedge txd);
         if (mon_en) begin
            start_len = 0;
            f = '0;
            while (txd === 1'b0) begin
               @(posedge clk);
               #1;
               start_len++;
            end
            repeat (bit_clks / 2) @(posedge clk);
            for (int i = 0; i < (nine ? 9 : 8); i++) begin
               if (i > 0) repeat (bit_clks) @(posedge clk);
               #1 f[i] = txd;
               f[11] = flag_probe;
            end
            repeat (bit_clks) @(posedge clk);
            #1 f[9] = txd;
            f[10] = flag_probe;
            got_q.push_back(f);
         end
      end
   end

   // ************************************
   // Frame source
   // ************************************
   // bit timing and framing
   task automatic send(input logic [8:0] d, input logic n9);
      for (int i = -1; i < (n9 ? 10 : 9); i++) begin
         @(posedge clk);
         rxd <= (i < 0) ? 1'b0 : (i == (n9 ? 9 : 8)) ? 1'b1 : d[i];
         repeat (bit_clks - 1) @(posedge clk);
      end
   endtask
endmodule

// ### test/uart_data_buffer_baud_setup_tb_top.sv
// Bench for the serial data buffer: register port, baud timing, both line directions.
// Assumes udb_remote on the line side and the shared package udb_pkg.
`timescale 1ns/1ps
module uart_data_buffer_baud_setup_tb_top;
   import udb_pkg::*;
   logic clk, rst, tx_done_clear, rx_done_clear, rxd, txd, mon_en;
   logic ext = 1'b0;
   logic sfr_wr_ready, tx_done_flag, rx_done_flag, ninth_rx_bit;
   logic [7:0] sfr_rdata, rd_v, latch_m;
   logic [8:0] rx_d;
   logic [8:0] exp_q[$];
   logic [15:0] bit_clks;
   logic flag_m, nrx_m;
   logic [4:0] n9v = 5'b11100;
   logic [4:0] mcev = 5'b01100;
   logic [4:0] ninthv = 5'b01000;
   logic [4:0] clrv = 5'b10101;
   udb_sfr_t sfr;
   udb_cfg_t cfg;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   int seed = 44;
   int n;

   udb_uart #(.FIFO_DEPTH(UDB_FIFO_DEPTH)) DUT (.clk(clk), .rst(rst), .sfr(sfr),
      .sfr_rdata(sfr_rdata), .sfr_wr_ready(sfr_wr_ready), .cfg(cfg),
      .tx_done_clear(tx_done_clear), .rx_done_clear(rx_done_clear),
      .tx_done_flag(tx_done_flag), .rx_done_flag(rx_done_flag), .ninth_rx_bit(ninth_rx_bit),
      .external_osc_clock(ext), .rxd(rxd), .txd(txd));
   udb_remote u_remote (.clk(clk), .txd(txd), .rxd(rxd), .mon_en(mon_en),
      .nine(cfg.nine_bit_mode), .flag_probe(tx_done_flag), .bit_clks(bit_clks));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // The external clock rises every second cycle, so each of its counts is two clk.
   always @(posedge clk) begin
      ext <= ~ext;
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         failures++;
         print_verdict();
      end
   end

   // Clearing at each frame start lets every frame show its own flag timing.
   always @(negedge txd) begin
      @(posedge clk);
      tx_done_clear <= 1'b1;
      @(posedge clk);
      tx_done_clear <= 1'b0;
   end

   // ************************************
   // Tasks
   // ************************************
   task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask

   task automatic cmp_frame(input logic [11:0] g, input logic [11:0] e);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask

   task automatic cmp_len(input int g, input int e);
      checks_done++;
      if (g != e) begin
         failures++;
         $display("Error at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] d);
      @(posedge clk);
      sfr <= '{UDB_SBUF_ADDR, 1'b1, 1'b0, d};
      @(posedge clk);
      sfr.wr <= 1'b0;
   endtask

   task automatic rd(output logic [7:0] v);
      @(posedge clk);
      sfr <= '{UDB_SBUF_ADDR, 1'b0, 1'b1, 8'h00};
      @(posedge clk);
      sfr.rd <= 1'b0;
      #1 v = sfr_rdata;
   endtask

   task automatic send_tx(input logic [7:0] d);
      wr(d);
      exp_q.push_back({cfg.nine_bit_mode & cfg.ninth_tx_bit, d});
   endtask

   task automatic setcfg(input logic n9, mce, tb, tcs, input logic [1:0] c, input logic [7:0] rl);
      @(posedge clk);
      cfg <= '{n9, mce, 1'b1, tb, tcs, c, rl};
   endtask

   task automatic drain();
      logic [8:0] e;
      while (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         for (int t = 0; t < 40000 && u_remote.got_q.size() == 0; t++) @(posedge clk);
         cmp_frame(u_remote.got_q.pop_front(), {3'b011, e});
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ************************************
   // Main sequence
   // ************************************
   initial begin
      rst = 1'b1;
      tx_done_clear = 1'b0;
      rx_done_clear = 1'b0;
      mon_en = 1'b1;
      sfr = '0;
      cfg = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0, 8'h96};
      bit_clks = 16'd212;
      flag_m = 1'b0;
      nrx_m = 1'b0;
      latch_m = UDB_SBUF_RESET;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(rd_v);
      cmp_reg(rd_v, UDB_SBUF_RESET);
      $display("reset test done");
      for (int c = 0; c < 4; c++) begin
         setcfg(1'b0, 1'b0, 1'b0, 1'b0, 2'(c), UDB_TIMER_TOP);
         bit_clks = 16'(2 * ((c == 3) ? 2 * UDB_DIV_EXT : (c == 0) ? UDB_DIV12 :
            (c == 1) ? UDB_DIV4 : UDB_DIV48));
         send_tx(8'($random(seed)) | 8'h01);
         drain();
         cmp_len(u_remote.start_len, bit_clks);
      end
      $display("prescale test done");
      setcfg(1'b1, 1'b0, 1'b1, 1'b1, 2'h0, 8'h96);
      bit_clks = 16'd212;
      for (int k = 0; k < 20; k++) begin
         @(posedge clk);
         #1 if (sfr_wr_ready !== 1'b1) break;
         send_tx(8'($random(seed)) | 8'h01);
      end
      cmp_reg({7'h0, sfr_wr_ready}, 8'h00);
      wr(8'hA4);
      drain();
      cmp_len(u_remote.start_len, 212);
      repeat (3000) @(posedge clk);
      cmp_len(u_remote.got_q.size(), 0);
      $display("queue test done");
      for (int i = 0; i < 5; i++) begin
         setcfg(n9v[i], mcev[i], 1'b0, 1'b1, 2'h0, 8'h96);
         if (clrv[i]) begin
            @(posedge clk);
            rx_done_clear <= 1'b1;
            @(posedge clk);
            rx_done_clear <= 1'b0;
            flag_m = 1'b0;
         end
         rx_d = {ninthv[i], 8'($random(seed))};
         if (i == 0) send_tx(8'h5B);
         u_remote.send(rx_d, n9v[i]);
         if (!flag_m && (!mcev[i] || !n9v[i] || rx_d[8])) begin
            latch_m = rx_d[7:0];
            nrx_m = n9v[i] ? rx_d[8] : 1'b1;
            flag_m = 1'b1;
         end
         repeat (2) @(posedge clk);
         rd(rd_v);
         cmp_reg(rd_v, latch_m);
         cmp_reg({6'h0, rx_done_flag, ninth_rx_bit}, {6'h0, flag_m, nrx_m});
      end
      // A disabled receiver ignores a whole frame; enabled again, it loads it.
      for (int j = 0; j < 2; j++) begin
         @(posedge clk);
         cfg.receive_enable_bit <= 1'(j);
         rx_done_clear <= 1'b1;
         @(posedge clk);
         rx_done_clear <= 1'b0;
         u_remote.send(9'h1C3, 1'b1);
         repeat (2) @(posedge clk);
         rd(rd_v);
         cmp_reg(rd_v, (j == 1) ? 8'hC3 : latch_m);
         cmp_reg({6'h0, rx_done_flag, ninth_rx_bit}, {6'h0, 1'(j), 1'(j) | nrx_m});
      end
      drain();
      $display("receive test done");
      mon_en = 1'b0;
      setcfg(1'b0, 1'b0, 1'b0, 1'b0, UDB_PS_EXT8, 8'h70);
      wr(8'hFF);
      for (int t = 0; t < 20000 && txd !== 1'b0; t++) begin
         @(posedge clk);
         #1;
      end
      n = 0;
      while (txd === 1'b0 && n < 9000) begin
         @(posedge clk);
         #1;
         n++;
      end
      cmp_len(n, 2 * 2304);
      @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(rd_v);
      cmp_reg(rd_v, UDB_SBUF_RESET);
      cmp_reg({7'h0, txd}, 8'h01);
      cmp_reg({4'h0, tx_done_flag, rx_done_flag, ninth_rx_bit, sfr_wr_ready}, 8'h01);
      $display("external clock test done");
      print_verdict();
   end
endmodule
